// ==== hdl/uart_baud_irda_config.sv ====
// Serial transceiver with rate divisor, rate detection, infrared shaping and transmit FIFO.
// Contract
// - Divisor is 16 bits, low byte at base index, high byte next.
// - Writing the divisor reloads the prescaler at once; frames may corrupt.
// - Window field picks 18, 15, 21 or 25 percent sync tolerance.
// - Halted processor without run bit freezes the block and ignores events.
// - Event input enable feeds infrared receiver from event, ignoring the pin.
// - Pulse length zero makes each pulse three sixteenths of a bit.
// - Values one to 0xFE give pulses that many clocks from bit start.
// - All ones disables pulse coding; signals pass straight through.
// - Pulse length matters only in infrared mode; set before transmitter on.
// - Seven-bit filter off at zero; otherwise needs N+1 samples to accept.
// - Filter applies only in infrared mode; set before receiver on.
// - Receive mode selects normal, double, generic or constrained rate detection.
// - Constrained detection needs each two bits within window of 32 samples.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps

module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : tx_fifo

module uart_baud_irda_config
    import uart_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    input wire logic ir_event_in,
    input wire logic cpu_halted,
    output logic tx_pin,
    output logic tx_pin_oe
);
    comm_cfg_s cfg;
    logic [7:0] rate_divisor_low, rate_divisor_high, tx_pulse_length;
    logic [15:0] divisor;
    logic [1:0] sync_window_size;
    logic run_while_halted, ir_event_input_enable;
    logic [6:0] rx_pulse_filter;
    logic rx_full, sync_ok, sync_fail;
    logic [7:0] rx_data, read_val;
    logic [4:0] idx;
    logic access, hit, stall, wr, rd, run, sample_tick;
    logic [15:0] presc_cnt;
    logic [4:0] spb;
    logic fifo_ready, fifo_valid, fifo_pop;
    logic [7:0] fifo_data;
    line_state_e tx_state;

    assign divisor = {rate_divisor_high, rate_divisor_low};
    assign idx = paddr[6:2];
    assign access = psel & penable;
    assign hit = paddr[1:0] == 2'b00 && !paddr[7] && idx >= IDX_COMM_CONTROL
                 && idx <= IDX_TX_DATA;
    assign stall = pwrite && idx == IDX_TX_DATA && !fifo_ready;
    assign wr = access & pready & pwrite & ~pslverr;
    assign rd = access & pready & ~pwrite & ~pslverr;
    // A halted processor freezes the block unless the run bit is set.
    assign run = !cpu_halted || run_while_halted;
    assign spb = (cfg.comm_mode_select == COMM_ASYNC && cfg.receive_mode_select == RX_DOUBLE)
                 ? SAMPLES_DOUBLE : SAMPLES_NORMAL;

    always_comb begin
        read_val = 8'h00;
        unique case (idx)
            IDX_COMM_CONTROL: read_val = {2'b00, cfg};
            IDX_STATUS: read_val = {3'b000, (tx_state == LINE_BUSY) | fifo_valid, ~fifo_ready,
                                    sync_fail, sync_ok, rx_full};
            IDX_RX_DATA: read_val = rx_data;
            IDX_DIV_LOW: read_val = rate_divisor_low;
            IDX_DIV_HIGH: read_val = rate_divisor_high;
            IDX_AUTORATE: read_val = {sync_window_size, 6'h00};
            IDX_DEBUG: read_val = {7'h00, run_while_halted};
            IDX_IR_EVENT: read_val = {7'h00, ir_event_input_enable};
            IDX_TX_PULSE: read_val = tx_pulse_length;
            IDX_RX_FILTER: read_val = {1'b0, rx_pulse_filter};
            default: read_val = 8'h00;
        endcase
    end

    // One wait state; a write to a full FIFO holds pready low until a word drains.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (access && !pready && !stall) begin
            pready <= 1'b1;
            pslverr <= !hit;
            prdata <= {24'h00_0000, read_val};
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Rate detection state, declared here because it loads the divisor.
    logic ab_load;
    logic [15:0] ab_value;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg <= '0;
            rate_divisor_low <= RST_BYTE;
            rate_divisor_high <= RST_BYTE;
            sync_window_size <= 2'b00;
            run_while_halted <= 1'b0;
            ir_event_input_enable <= 1'b0;
            tx_pulse_length <= RST_BYTE;
            rx_pulse_filter <= 7'h00;
        end else if (wr) begin
            unique case (idx)
                IDX_COMM_CONTROL: cfg <= comm_cfg_s'(pwdata[5:0]);
                IDX_DIV_LOW: rate_divisor_low <= pwdata[7:0];
                IDX_DIV_HIGH: rate_divisor_high <= pwdata[7:0];
                IDX_AUTORATE: sync_window_size <= pwdata[POS_WINDOW +: 2];
                IDX_DEBUG: run_while_halted <= pwdata[POS_RUN_HALTED];
                IDX_IR_EVENT: ir_event_input_enable <= pwdata[POS_EVENT_IN];
                IDX_TX_PULSE: tx_pulse_length <= pwdata[7:0];
                IDX_RX_FILTER: rx_pulse_filter <= pwdata[6:0];
                default: ;
            endcase
        end else if (ab_load) begin
            {rate_divisor_high, rate_divisor_low} <= ab_value;
        end
    end

    logic div_wr;
    logic [15:0] next_divisor;
    assign div_wr = wr && (idx == IDX_DIV_LOW || idx == IDX_DIV_HIGH);
    assign next_divisor = (idx == IDX_DIV_LOW) ? {rate_divisor_high, pwdata[7:0]}
                                               : {pwdata[7:0], rate_divisor_low};

    // The prescaler reloads on the write itself, so a frame in flight may break.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            presc_cnt <= RST_DIVISOR;
        end else if (div_wr) begin
            presc_cnt <= next_divisor;
        end else if (ab_load) begin
            presc_cnt <= ab_value;
        end else if (run) begin
            presc_cnt <= (presc_cnt == 16'h0000) ? divisor : presc_cnt - 16'h0001;
        end
    end
    assign sample_tick = run && presc_cnt == 16'h0000;

    tx_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(wr && idx == IDX_TX_DATA),
        .in_ready(fifo_ready),
        .in_data(pwdata[7:0]),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Transmitter.
    logic [9:0] tx_shift;
    logic [3:0] tx_bits;
    logic [4:0] tx_phase;
    logic tx_bit, bit_end, pulse_start, ir_active;
    logic [7:0] pulse_left;

    assign ir_active = cfg.comm_mode_select == COMM_INFRARED
                       && tx_pulse_length != TX_PULSE_OFF;
    assign fifo_pop = run && tx_state == LINE_IDLE && cfg.transmitter_on && fifo_valid;
    assign bit_end = sample_tick && tx_phase == spb - 5'h01;
    assign tx_bit = (tx_state == LINE_IDLE) ? 1'b1 : tx_shift[0];
    assign pulse_start = ir_active && ((fifo_pop) ||
                         (tx_state == LINE_BUSY && bit_end && tx_bits != LAST_FRAME_BIT
                          && !tx_shift[1]));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state <= LINE_IDLE;
            tx_shift <= 10'h3ff;
            tx_bits <= 4'h0;
            tx_phase <= 5'h00;
        end else if (fifo_pop) begin
            tx_state <= LINE_BUSY;
            tx_shift <= {1'b1, fifo_data, 1'b0};
            tx_bits <= 4'h0;
            tx_phase <= 5'h00;
        end else if (tx_state == LINE_BUSY && sample_tick) begin
            tx_phase <= bit_end ? 5'h00 : tx_phase + 5'h01;
            if (bit_end) begin
                tx_shift <= {1'b1, tx_shift[9:1]};
                tx_bits <= tx_bits + 4'h1;
                if (tx_bits == LAST_FRAME_BIT) begin
                    tx_state <= LINE_IDLE;
                end
            end
        end
    end

    // Pulses mark zero bits and start together with the bit.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_left <= 8'h00;
        end else if (pulse_start) begin
            pulse_left <= (tx_pulse_length == 8'h00) ? IR_PULSE_SAMPLES : tx_pulse_length;
        end else if (pulse_left != 8'h00 && run && (tx_pulse_length != 8'h00 || sample_tick)) begin
            pulse_left <= pulse_left - 8'h01;
        end
    end

    // The pin stays driven until the frame in flight has finished.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_pin <= 1'b1;
            tx_pin_oe <= 1'b0;
        end else begin
            tx_pin <= ir_active ? (pulse_left != 8'h00) : tx_bit;
            tx_pin_oe <= cfg.transmitter_on || tx_state == LINE_BUSY;
        end
    end

    // Receive front end with infrared pulse filter.
    logic raw_src, rx_level, rx_prev, pulse_taken, ir_accept;
    logic [6:0] hi_cnt;
    logic [4:0] ir_hold;

    assign raw_src = ir_event_input_enable ? ir_event_in : rx_pin;
    assign ir_accept = ir_active && raw_src && !pulse_taken && hi_cnt == rx_pulse_filter;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_cnt <= 7'h00;
            pulse_taken <= 1'b0;
            ir_hold <= 5'h00;
            rx_level <= 1'b1;
            rx_prev <= 1'b1;
        end else if (run) begin
            rx_prev <= rx_level;
            if (!raw_src) begin
                hi_cnt <= 7'h00;
                pulse_taken <= 1'b0;
            end else if (ir_accept) begin
                pulse_taken <= 1'b1;
            end else if (hi_cnt != rx_pulse_filter) begin
                hi_cnt <= hi_cnt + 7'h01;
            end
            if (ir_accept) begin
                ir_hold <= spb;
            end else if (sample_tick && ir_hold != 5'h00) begin
                ir_hold <= ir_hold - 5'h01;
            end
            rx_level <= ir_active ? (ir_hold == 5'h00 && !ir_accept) : raw_src;
        end
    end

    // Receiver, sampling each bit at its middle.
    line_state_e rx_state;
    logic [4:0] rx_phase;
    logic [3:0] rx_bits;
    logic [7:0] rx_shift;
    logic rx_done, rx_mid;

    assign rx_mid = sample_tick && rx_phase == {1'b0, spb[4:1]};
    assign rx_done = rx_state == LINE_BUSY && rx_mid && rx_bits == LAST_FRAME_BIT && rx_level;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state <= LINE_IDLE;
            rx_phase <= 5'h00;
            rx_bits <= 4'h0;
            rx_shift <= 8'h00;
            rx_data <= 8'h00;
        end else if (rx_state == LINE_IDLE) begin
            if (run && cfg.receiver_on && rx_prev && !rx_level) begin
                rx_state <= LINE_BUSY;
                rx_phase <= 5'h00;
                rx_bits <= 4'h0;
            end
        end else if (sample_tick) begin
            rx_phase <= (rx_phase == spb - 5'h01) ? 5'h00 : rx_phase + 5'h01;
            if (rx_mid) begin
                rx_bits <= rx_bits + 4'h1;
                rx_shift <= {rx_level, rx_shift[7:1]};
                if ((rx_bits == 4'h0 && rx_level) || rx_bits == LAST_FRAME_BIT) begin
                    rx_state <= LINE_IDLE;
                end
                if (rx_done) begin
                    rx_data <= rx_shift;
                end
            end
        end
    end

    // Rate detection on the alternating sync character.
    logic ab_enabled, ab_fall, ab_good, ab_in_window;
    logic [2:0] ab_edges;
    logic [7:0] ab_period, tol;
    logic [22:0] ab_clocks, ab_total;

    assign ab_enabled = cfg.comm_mode_select == COMM_ASYNC && cfg.receiver_on
                        && cfg.receive_mode_select[1];
    assign ab_fall = run && ab_enabled && rx_prev && !rx_level;
    always_comb begin
        unique case (sync_window_size)
            2'b00: tol = TOL_W0;
            2'b01: tol = TOL_W1;
            2'b10: tol = TOL_W2;
            2'b11: tol = TOL_W3;
        endcase
    end
    assign ab_in_window = ab_period >= SYNC_PERIOD - tol && ab_period <= SYNC_PERIOD + tol;
    // Rounding to the nearest sample keeps an exact sync character from landing one below.
    assign ab_total = ab_clocks + (23'h00_0001 << (RATE_SHIFT - 1));
    assign ab_value = ab_total[22:RATE_SHIFT] - 16'h0001;
    assign ab_load = ab_fall && ab_edges == SYNC_PERIODS && !div_wr && ab_value != 16'hffff
                     && ab_good && (cfg.receive_mode_select == RX_GENERIC_RATE_DETECT
                                    || ab_in_window);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ab_edges <= 3'h0;
            ab_period <= 8'h00;
            ab_clocks <= 23'h00_0000;
            ab_good <= 1'b0;
        end else if (!ab_enabled || ab_period == 8'hff) begin
            ab_edges <= 3'h0;
            ab_period <= 8'h00;
        end else if (ab_fall) begin
            ab_period <= 8'h00;
            if (ab_edges == 3'h0) begin
                ab_edges <= 3'h1;
                ab_clocks <= 23'h00_0000;
                ab_good <= 1'b1;
            end else begin
                ab_edges <= (ab_edges == SYNC_PERIODS) ? 3'h0 : ab_edges + 3'h1;
                ab_good <= ab_good && (cfg.receive_mode_select == RX_GENERIC_RATE_DETECT
                                       || ab_in_window);
            end
        end else if (ab_edges != 3'h0 && run) begin
            ab_clocks <= ab_clocks + 23'h00_0001;
            if (sample_tick) begin
                ab_period <= ab_period + 8'h01;
            end
        end
    end

    // Hardware sets win over software clears.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_full <= 1'b0;
            sync_ok <= 1'b0;
            sync_fail <= 1'b0;
        end else begin
            rx_full <= rx_done || (rx_full && !(rd && idx == IDX_RX_DATA));
            sync_ok <= ab_load || (sync_ok && !(wr && idx == IDX_STATUS && pwdata[POS_SYNC_OK]));
            sync_fail <= (ab_fall && ab_edges == SYNC_PERIODS && !ab_load)
                         || (sync_fail && !(wr && idx == IDX_STATUS && pwdata[POS_SYNC_FAIL]));
        end
    end

    divisor_reload_a: assert property (@(posedge clk) disable iff (rst)
        div_wr |=> presc_cnt == divisor) else $error("prescaler not reloaded by divisor write");
    divisor_high_read_a: assert property (@(posedge clk) disable iff (rst)
        (access && !pready && !pwrite && idx == IDX_DIV_HIGH && hit)
        |=> prdata == {24'h00_0000, $past(rate_divisor_high)}) else $error("high byte misread");
    sync_window_a: assert property (@(posedge clk) disable iff (rst)
        (ab_fall && ab_edges > 3'h0 && ab_edges < SYNC_PERIODS && !ab_in_window
         && cfg.receive_mode_select == RX_CONSTRAINED_RATE_DETECT) |=> !ab_good)
        else $error("out of window sync period accepted");
    halt_freeze_a: assert property (@(posedge clk) disable iff (rst)
        (!run && !div_wr && !ab_load) |=> presc_cnt == $past(presc_cnt) && $stable(tx_state))
        else $error("block ran while halted");
    event_source_a: assert property (@(posedge clk) disable iff (rst)
        (ir_event_input_enable && run && !ir_active) |=> rx_level == $past(ir_event_in))
        else $error("event input not selected");
    short_pulse_a: assert property (@(posedge clk) disable iff (rst)
        (pulse_start && tx_pulse_length == 8'h00) |=> pulse_left == IR_PULSE_SAMPLES)
        else $error("three sixteenths pulse wrong");
    fixed_pulse_a: assert property (@(posedge clk) disable iff (rst)
        (pulse_start && tx_pulse_length != 8'h00) |=> pulse_left == $past(tx_pulse_length)
        ##1 tx_pin) else $error("fixed pulse length wrong");
    pass_through_a: assert property (@(posedge clk) disable iff (rst)
        !ir_active |=> tx_pin == $past(tx_bit)) else $error("pin not passed through");
    filter_samples_a: assert property (@(posedge clk) disable iff (rst)
        (ir_accept && rx_pulse_filter == 7'h02 && run && $past(run, 2))
        |-> $past(raw_src) && $past(raw_src, 2)) else $error("pulse accepted too early");
    detect_async_a: assert property (@(posedge clk) disable iff (rst)
        (cfg.comm_mode_select != COMM_ASYNC) |=> ab_edges == 3'h0 && !ab_load)
        else $error("rate detection outside async mode");
    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        (access && !pready && !pwrite && idx == IDX_DEBUG) |=> prdata[31:1] == 31'h0000_0000)
        else $error("reserved bits not zero");

    frame_sent_c: cover property (@(posedge clk) disable iff (rst)
        tx_state == LINE_BUSY ##1 tx_state == LINE_IDLE);
    byte_received_c: cover property (@(posedge clk) disable iff (rst) rx_done);
    rate_detected_c: cover property (@(posedge clk) disable iff (rst) ab_load);
    fifo_stall_c: cover property (@(posedge clk) disable iff (rst) access && stall);
endmodule : uart_baud_irda_config

// ==== hdl/uart_cfg_pkg.sv ====
// Constants, register map and shared types of the serial rate and infrared configuration block.
package uart_cfg_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    // Register indices; byte address is four times the index.
    localparam logic [4:0] IDX_COMM_CONTROL = 5'h05;
    localparam logic [4:0] IDX_STATUS = 5'h06;
    localparam logic [4:0] IDX_RX_DATA = 5'h07;
    localparam logic [4:0] IDX_DIV_LOW = 5'h08;
    localparam logic [4:0] IDX_DIV_HIGH = 5'h09;
    localparam logic [4:0] IDX_AUTORATE = 5'h0a;
    localparam logic [4:0] IDX_DEBUG = 5'h0b;
    localparam logic [4:0] IDX_IR_EVENT = 5'h0c;
    localparam logic [4:0] IDX_TX_PULSE = 5'h0d;
    localparam logic [4:0] IDX_RX_FILTER = 5'h0e;
    localparam logic [4:0] IDX_TX_DATA = 5'h0f;
    // Field positions.
    localparam int unsigned POS_TX_ON = 0;
    localparam int unsigned POS_RX_ON = 1;
    localparam int unsigned POS_RX_MODE = 2;
    localparam int unsigned POS_COMM_MODE = 4;
    localparam int unsigned POS_WINDOW = 6;
    localparam int unsigned POS_RUN_HALTED = 0;
    localparam int unsigned POS_EVENT_IN = 0;
    localparam int unsigned POS_RX_FULL = 0;
    localparam int unsigned POS_SYNC_OK = 1;
    localparam int unsigned POS_SYNC_FAIL = 2;
    localparam int unsigned POS_FIFO_FULL = 3;
    localparam int unsigned POS_TX_BUSY = 4;
    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_DIVISOR = 16'h0000;
    // Timing in sample ticks and clock cycles.
    localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
    localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
    localparam logic [7:0] IR_PULSE_SAMPLES = 8'h03;
    localparam logic [7:0] TX_PULSE_OFF = 8'hff;
    localparam logic [7:0] SYNC_PERIOD = 8'h20;
    localparam logic [7:0] TOL_W0 = 8'h06;
    localparam logic [7:0] TOL_W1 = 8'h05;
    localparam logic [7:0] TOL_W2 = 8'h07;
    localparam logic [7:0] TOL_W3 = 8'h08;
    localparam logic [2:0] SYNC_PERIODS = 3'h4;
    localparam int unsigned RATE_SHIFT = 7;
    localparam logic [3:0] LAST_FRAME_BIT = 4'h9;

    typedef enum logic [1:0] {
        COMM_ASYNC = 2'b00,
        COMM_SYNC = 2'b01,
        COMM_INFRARED = 2'b10,
        COMM_SPI_MASTER = 2'b11
    } comm_mode_e;

    typedef enum logic [1:0] {
        RX_NORMAL = 2'b00,
        RX_DOUBLE = 2'b01,
        RX_GENERIC_RATE_DETECT = 2'b10,
        RX_CONSTRAINED_RATE_DETECT = 2'b11
    } rx_mode_e;

    typedef enum logic [0:0] {
        LINE_IDLE = 1'b0,
        LINE_BUSY = 1'b1
    } line_state_e;

    typedef struct packed {
        comm_mode_e comm_mode_select;
        rx_mode_e receive_mode_select;
        logic receiver_on;
        logic transmitter_on;
    } comm_cfg_s;
endpackage : uart_cfg_pkg

// ==== sim/serial_node.sv ====
// Remote serial node that sends 8N1 frames on the receive line.
`timescale 1ns/10ps
module serial_node (
    input wire logic clk,
    output logic line
);
    // The line idles high between frames, as a pulled-up serial line does.
    initial line = 1'b1;
    task automatic send(input logic [7:0] b, input int clocks);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line <= f[i];
            repeat (clocks) @(posedge clk);
        end
    endtask : send
endmodule : serial_node

// ==== sim/uart_baud_irda_config_tb_top.sv ====
// Self-checking bench for the serial rate and infrared configuration block.
`timescale 1ns/10ps
module uart_baud_irda_config_tb_top;
    import uart_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, rx_line, tx_pin, tx_pin_oe;
    logic halted = 1'b0;
    logic ev_in = 1'b1;
    int bad_count = 0;
    int checked = 0;
    always #25 clk = ~clk;
    serial_node serial_node_i (.clk(clk), .line(rx_line));
    uart_baud_irda_config uart_baud_irda_config_i (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_pin(rx_line), .ir_event_in(ev_in),
        .cpu_halted(halted), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Pready is read just after the edge, so it is the value that edge sampled.
    task automatic apb(input logic w, input logic [4:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 100) begin
            check("pready", 1, 0);
            end_sim();
        end
    endtask : apb
    // Busy also covers queued words, so it stays set between queued frames; idle must still be seen twice running.
    task automatic wait_idle();
        int q;
        q = 0;
        for (int n = 0; n < 1000 && q < 2; n++) begin
            apb(0, IDX_STATUS, 8'h00);
            q = rd[POS_TX_BUSY] === 1'b0 ? q + 1 : 0;
        end
        check("tx busy", 0, rd[POS_TX_BUSY]);
    endtask : wait_idle
    task automatic t_regs();
        logic [4:0] idx [7] = '{IDX_DIV_LOW, IDX_DIV_HIGH, IDX_AUTORATE, IDX_DEBUG,
            IDX_IR_EVENT, IDX_TX_PULSE, IDX_RX_FILTER};
        logic [7:0] mask [7] = '{8'hff, 8'hff, 8'hc0, 8'h01, 8'h01, 8'hff, 8'h7f};
        for (int i = 0; i < 7; i++) begin
            apb(0, idx[i], 8'h00);
            check("reset value", 0, rd);
            apb(1, idx[i], 8'hff);
            apb(0, idx[i], 8'h00);
            check("writable bits", {24'h00_0000, mask[i]}, rd);
            apb(1, idx[i], 8'h00);
        end
        apb(1, IDX_DIV_LOW, 8'h34);
        apb(0, IDX_DIV_HIGH, 8'h00);
        check("divisor high", 0, rd);
        apb(1, IDX_DIV_LOW, 8'h00);
        apb(1, 5'h10, 8'h5a);
        check("unmapped error", 1, err);
    endtask : t_regs
    task automatic t_ir_tx();
        logic [7:0] len [2] = '{8'h05, 8'h00};
        int exp [2] = '{5, 3};
        int n;
        for (int i = 0; i < 2; i++) begin
            apb(1, IDX_COMM_CONTROL, 8'h20); // Receive mode stays zero
            apb(1, IDX_TX_PULSE, len[i]);
            apb(1, IDX_TX_DATA, 8'h00);
            apb(1, IDX_COMM_CONTROL, 8'h21);
            n = 0;
            while (tx_pin !== 1'b1 && n < 400) begin
                @(posedge clk);
                n++;
            end
            n = 0;
            while (tx_pin === 1'b1 && n < 400) begin
                @(posedge clk);
                n++;
            end
            check("pulse cycles", exp[i], n);
            wait_idle();
            apb(1, IDX_COMM_CONTROL, 8'h00);
        end
    endtask : t_ir_tx
    task automatic t_fifo();
        for (int i = 0; i < 8; i++) begin
            apb(1, IDX_TX_DATA, 8'(i));
        end
        apb(0, IDX_STATUS, 8'h00);
        check("fifo full", 1, rd[POS_FIFO_FULL]);
        apb(1, IDX_COMM_CONTROL, 8'h01);
        wait_idle();
        check("fifo drained", 0, rd[POS_FIFO_FULL]);
        apb(1, IDX_COMM_CONTROL, 8'h00);
    endtask : t_fifo
    task automatic t_rx();
        apb(1, IDX_COMM_CONTROL, 8'h02);
        @(posedge clk);
        serial_node_i.send(8'ha5, 16);
        apb(0, IDX_STATUS, 8'h00);
        check("rx full", 1, rd[POS_RX_FULL]);
        apb(0, IDX_RX_DATA, 8'h00);
        check("rx data", 32'h0000_00a5, rd);
        apb(0, IDX_STATUS, 8'h00);
        check("rx full cleared", 0, rd[POS_RX_FULL]);
    endtask : t_rx
    task automatic t_halt();
        int n;
        halted <= 1'b1;
        apb(1, IDX_TX_DATA, 8'h00);
        apb(1, IDX_COMM_CONTROL, 8'h01);
        repeat (40) @(posedge clk);
        check("halted line", 1, tx_pin);
        check("pin drive", 1, tx_pin_oe);
        apb(1, IDX_DEBUG, 8'h01);
        n = 0;
        while (tx_pin !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        check("run bit", 0, tx_pin);
        wait_idle();
        apb(1, IDX_COMM_CONTROL, 8'h00);
        apb(1, IDX_DEBUG, 8'h00);
        halted <= 1'b0;
    endtask : t_halt
    task automatic t_event();
        apb(1, IDX_IR_EVENT, 8'h01);
        apb(1, IDX_COMM_CONTROL, 8'h02);
        serial_node_i.send(8'h3c, 16);
        apb(0, IDX_STATUS, 8'h00);
        check("pin ignored", 0, rd[POS_RX_FULL]);
        ev_in <= 1'b0;
        repeat (144) @(posedge clk);
        ev_in <= 1'b1;
        repeat (20) @(posedge clk);
        apb(0, IDX_RX_DATA, 8'h00);
        check("event frame", 0, rd);
        apb(1, IDX_IR_EVENT, 8'h00);
    endtask : t_event
    task automatic t_rate();
        apb(1, IDX_COMM_CONTROL, 8'h0a);
        serial_node_i.send(8'h55, 32);
        apb(0, IDX_DIV_LOW, 8'h00);
        check("detected divisor", 1, rd);
        apb(0, IDX_STATUS, 8'h00);
        check("sync ok", 1, rd[POS_SYNC_OK]);
        apb(1, IDX_STATUS, 8'h02);
        apb(1, IDX_COMM_CONTROL, 8'h0e);
        serial_node_i.send(8'h55, 48);
        apb(0, IDX_STATUS, 8'h00);
        check("sync rejected", 32'h0000_0004, rd & 32'h0000_0006);
        apb(0, IDX_DIV_LOW, 8'h00);
        check("divisor kept", 1, rd);
        apb(1, IDX_COMM_CONTROL, 8'h00);
    endtask : t_rate
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_ir_tx();
        t_fifo();
        t_halt();
        t_rx();
        t_event();
        t_rate();
        end_sim();
    end
endmodule : uart_baud_irda_config_tb_top
